// *** shared/smr_defines.svh ***
// Register offsets, field positions, reset values for mode/reset control
// Assumes 4-bit register index on a plain strobe port, 8-bit data
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

// Register indices
`define SMR_OFS_OUT    4'h0
`define SMR_OFS_DIAG   4'h1
`define SMR_OFS_HWCFG  4'h2
`define SMR_OFS_STAT   4'h3
`define SMR_OFS_THERM  4'h4

// Config register fields
`define SMR_HW_CH5_BIT   3
`define SMR_HW_CRANK_BIT 2
`define SMR_HW_STBY_BIT  1
`define SMR_HW_RST_BIT   1

// Status register fields
`define SMR_ST_LIMP_BIT 0
`define SMR_ST_XERR_BIT 1
`define SMR_ST_IDLE_BIT 2

// Reset values and stand-by mux select code
`define SMR_RST_OUT    6'h00
`define SMR_RST_MUX    3'h7
`define SMR_MUX_STBY   3'h7
`define SMR_RST_CRANK  1'b1
// Serial pin idle levels {select, clock}: select high, clock low
`define SMR_RST_SPI    2'h2

`endif

// *** shared/smr_pkg.sv ***
// Types shared by the mode/reset control design
// Assumes nothing beyond the defines header
package smr_pkg;

  // Operating mode, one-hot
  typedef enum logic [2:0] {
    SMR_MODE_AWAKE = 3'b001,
    SMR_MODE_STBY  = 3'b010,
    SMR_MODE_LIMP  = 3'b100
  } smr_mode_type;

endpackage

// *** core/smr_sync.sv ***
// Two-flop synchroniser for a group of asynchronous levels
// Assumes inputs come from pins outside the clk_in domain
`timescale 1ns/1ns
module smr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage read only by second stage; reset to idle level, no false edge
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** core/smr_crank_latch.sv ***
// Channel 5 cranking latch
// Assumes request and enable already in the clk_in domain
`timescale 1ns/1ns
module smr_crank_latch (
  // Clock and power-up reset only
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Control
  input  wire logic latch_en_in,
  input  wire logic set_req_in,
  // State
  output logic      latched_out
);

  logic latch_q;
  logic latch_d;

  // Set by request, cleared only when latching disabled
  assign latch_d = !latch_en_in ? 1'b0 :
                   set_req_in   ? 1'b1 : latch_q;

  // No supply-dip input: latch holds through cranking
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      latch_q <= 1'b0;
    else
      latch_q <= latch_d;
  end

  assign latched_out = latch_q;

endmodule

// *** core/smr_core.sv ***
// Supply mode and reset control: register bank, stand-by, limp-home, crank
// Assumes clk_in at 250 MHz, plain strobe register port from the host side,
// serial select and clock pins sampled as plain asynchronous inputs
`timescale 1ns/1ns
`include "smr_defines.svh"
module smr_core
  import smr_pkg::*;
(
  // Clock and logic supply power-on reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Serial frame pins
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_sclk_in,
  // Mode and channel pins
  input  wire logic       limp_home_in,
  input  wire logic [5:0] channel_input_pins_in,
  input  wire logic [5:0] thermal_fault_in,
  // Power stage and status outputs
  output logic      [5:0] channel_outputs_out,
  output logic      [2:0] sense_mux_select_out,
  output logic            so_out_reg_sel_out,
  output logic            transfer_error_out,
  output logic            standby_out,
  output logic            idle_out,
  output logic            limp_mode_out,
  output logic            current_sense_en_out,
  output logic            reg_reset_out
);

  // Synchronised pins
  logic       limp_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic [5:0] pins_s;
  logic [5:0] therm_s;

  // Register bank
  logic [5:0] out_cmd_q;
  logic [5:0] out_cmd_d;
  logic [2:0] mux_q;
  logic [2:0] mux_d;
  logic       crank_en_q;
  logic       crank_en_d;
  logic       soft_rst_q;
  logic       soft_rst_d;
  logic [5:0] therm_q;
  logic [5:0] therm_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Serial frame tracking
  logic       cs_n_prev_q;
  logic       sclk_prev_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic       bit_seen_q;
  logic       bit_seen_d;
  logic       first_q;
  logic       first_d;
  logic       xfer_err_q;
  logic       xfer_err_d;

  // Mode and power stage
  smr_mode_type mode_q;
  smr_mode_type mode_d;
  logic [5:0]   chan_q;
  logic [5:0]   chan_d;
  logic         idle_q;
  logic         sense_en_q;
  logic         reg_rst_q;

  // Level synchronisers for every pin
  smr_sync #(
    .WIDTH (1)
  ) u_limp_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (limp_home_in),
    .sync_out (limp_s)
  );

  smr_sync #(
    .WIDTH   (2),
    .RST_VAL (`SMR_RST_SPI)
  ) u_spi_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({spi_cs_n_in, spi_sclk_in}),
    .sync_out ({cs_n_s, sclk_s})
  );

  smr_sync #(
    .WIDTH (12)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({thermal_fault_in, channel_input_pins_in}),
    .sync_out ({therm_s, pins_s})
  );

  // Reset of registers and flags: power-on, soft command, limp-home
  wire reg_rst = !nrst_in || soft_rst_q || limp_s;

  // Address decode; writes are discarded during limp-home
  wire wr_ok     = reg_wr_in && !limp_s;
  wire wr_out    = wr_ok && (reg_addr_in == `SMR_OFS_OUT);
  wire wr_diag   = wr_ok && (reg_addr_in == `SMR_OFS_DIAG);
  wire wr_hwcfg  = wr_ok && (reg_addr_in == `SMR_OFS_HWCFG);

  // Channel 5 requests from pin and command register
  wire ch5_req   = pins_s[5] || out_cmd_q[5];
  wire latch_en  = crank_en_q && !limp_s;
  wire ch5_latch;

  smr_crank_latch u_crank (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .latch_en_in (latch_en),
    .set_req_in  (ch5_req),
    .latched_out (ch5_latch)
  );

  // Commanded channel state: pins only in limp-home
  wire [5:0] cmd_norm = out_cmd_q | pins_s;
  wire [5:0] cmd_sel  = limp_s ? pins_s : cmd_norm;
  wire       ch5_on   = cmd_sel[5] || ch5_latch;

  // Thermal shutdown gates each channel
  assign chan_d = {ch5_on, cmd_sel[4:0]} & ~therm_q;

  // Stand-by condition ignores pins 0 to 4; pin 5 counts through channel 5 output state
  wire mux_stby  = (mux_q == `SMR_MUX_STBY);
  wire stby_cond = mux_stby && !chan_q[5];

  // Mode transitions
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      SMR_MODE_AWAKE:
      begin
        if (limp_s)
          mode_d = SMR_MODE_LIMP;
        else if (stby_cond)
          mode_d = SMR_MODE_STBY;
      end
      SMR_MODE_STBY:
      begin
        if (limp_s)
          mode_d = SMR_MODE_LIMP;
        else if (!stby_cond)
          mode_d = SMR_MODE_AWAKE;
      end
      SMR_MODE_LIMP:
      begin
        if (!limp_s)
          mode_d = SMR_MODE_AWAKE;
      end
      default:
        mode_d = SMR_MODE_AWAKE;
    endcase
  end

  wire stby_entry = (mode_d == SMR_MODE_STBY) && (mode_q != SMR_MODE_STBY);

  // Thermal latches: fault sets, stand-by entry or register reset clears
  assign therm_d = therm_s | ((stby_entry || reg_rst) ? 6'h00 : therm_q);

  // Register next values
  assign out_cmd_d  = wr_out  ? reg_wdata_in[5:0] : out_cmd_q;
  assign mux_d      = wr_diag ? reg_wdata_in[2:0] : mux_q;
  assign crank_en_d = wr_hwcfg ? reg_wdata_in[`SMR_HW_CRANK_BIT] : crank_en_q;
  assign soft_rst_d = wr_hwcfg && reg_wdata_in[`SMR_HW_RST_BIT];

  // Read views
  wire [7:0] hw_rd = {4'h0,
                      chan_q[5],
                      crank_en_q,
                      (mode_q == SMR_MODE_STBY),
                      1'b0};
  wire [7:0] stat_rd = {5'h00, idle_q, xfer_err_q, limp_s};
  wire [7:0] out_rd  = {2'h0, out_cmd_q};
  wire [7:0] diag_rd = {5'h00, mux_q};
  wire [7:0] therm_rd = {2'h0, therm_q};

  // Read mux, unmapped reads as zero
  assign rdata_d = !reg_rd_in                          ? 8'h00    :
                   (reg_addr_in == `SMR_OFS_OUT)       ? out_rd   :
                   (reg_addr_in == `SMR_OFS_DIAG)      ? diag_rd  :
                   (reg_addr_in == `SMR_OFS_HWCFG)     ? hw_rd    :
                   (reg_addr_in == `SMR_OFS_STAT)      ? stat_rd  :
                   (reg_addr_in == `SMR_OFS_THERM)     ? therm_rd : 8'h00;

  // Serial frame edges, seen on sampled select and clock
  wire frame_act  = !cs_n_s;
  wire frame_end  = cs_n_s && !cs_n_prev_q;
  wire sclk_rise  = sclk_s && !sclk_prev_q && frame_act;
  wire frame_bad  = (bit_cnt_q != 3'h0) || !bit_seen_q;

  // Bit count modulo eight within a frame
  assign bit_cnt_d  = frame_end ? 3'h0 :
                      sclk_rise ? bit_cnt_q + 3'h1 : bit_cnt_q;
  assign bit_seen_d = frame_end ? 1'b0 : (bit_seen_q || sclk_rise);

  // First frame after reset shows output register, error flagged
  assign first_d = frame_end ? 1'b0 : first_q;
  assign xfer_err_d = frame_end ? frame_bad : xfer_err_q;

  // Register bank, reset by every reset source
  always_ff @(posedge clk_in)
  begin
    if (reg_rst)
    begin
      out_cmd_q  <= `SMR_RST_OUT;
      mux_q      <= `SMR_RST_MUX;
      crank_en_q <= `SMR_RST_CRANK;
    end
    else
    begin
      out_cmd_q  <= out_cmd_d;
      mux_q      <= mux_d;
      crank_en_q <= crank_en_d;
    end
  end

  // Soft reset pulse, cleared by power-on reset only
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= soft_rst_d && !soft_rst_q;
  end

  // Thermal latches
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      therm_q <= 6'h00;
    else
      therm_q <= therm_d;
  end

  // Serial frame state, runs with no dependence on power supply
  always_ff @(posedge clk_in)
  begin
    if (reg_rst)
    begin
      first_q    <= 1'b1;
      xfer_err_q <= 1'b1;
      bit_cnt_q  <= 3'h0;
      bit_seen_q <= 1'b0;
    end
    else
    begin
      first_q    <= first_d;
      xfer_err_q <= xfer_err_d;
      bit_cnt_q  <= bit_cnt_d;
      bit_seen_q <= bit_seen_d;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // Power stage state: only power-up clears it, never soft or limp reset
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      chan_q <= 6'h00;
    else
      chan_q <= chan_d;
  end

  // Mode register
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      mode_q <= SMR_MODE_AWAKE;
    else
      mode_q <= mode_d;
  end

  // Idle and sensing status
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      idle_q     <= 1'b0;
      sense_en_q <= 1'b0;
    end
    else
    begin
      idle_q     <= (chan_q == 6'h00) && !mux_stby && !limp_s;
      sense_en_q <= !limp_s && (mode_q == SMR_MODE_AWAKE);
    end
  end

  // Read data and reset indication
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      rdata_q   <= 8'h00;
      reg_rst_q <= 1'b1;
    end
    else
    begin
      rdata_q   <= rdata_d;
      reg_rst_q <= soft_rst_q || limp_s;
    end
  end

  // Outputs straight from flops; standby_out and limp_mode_out decoded from mode_q
  assign reg_rdata_out        = rdata_q;
  assign channel_outputs_out  = chan_q;
  assign sense_mux_select_out = mux_q;
  assign so_out_reg_sel_out   = first_q;
  assign transfer_error_out   = xfer_err_q;
  assign standby_out          = (mode_q == SMR_MODE_STBY);
  assign idle_out             = idle_q;
  assign limp_mode_out        = (mode_q == SMR_MODE_LIMP);
  assign current_sense_en_out = sense_en_q;
  assign reg_reset_out        = reg_rst_q;

endmodule

// *** verification/smr_core_checker.sv ***
// Checker: port assertions for the mode and reset control
// Assumes a bind onto smr_core, one clk_in domain
`timescale 1ns/1ns
module smr_core_checker (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       nrst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  // Pins
  input wire logic       limp_home_in,
  input wire logic [5:0] channel_input_pins_in,
  // Outputs
  input wire logic [5:0] channel_outputs_out,
  input wire logic [2:0] sense_mux_select_out,
  input wire logic       so_out_reg_sel_out,
  input wire logic       transfer_error_out,
  input wire logic       standby_out,
  input wire logic       idle_out,
  input wire logic       limp_mode_out,
  input wire logic       current_sense_en_out,
  input wire logic       reg_reset_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Helper slices
  wire logic [2:0] wmux = reg_wdata_in[2:0];
  wire logic       ch5  = channel_outputs_out[5];
  wire logic       pin5 = channel_input_pins_in[5];

  a_mux_write: assert property (reg_wr_in && reg_addr_in == 4'h1 &&
    !limp_mode_out && !limp_home_in |=> sense_mux_select_out == $past(wmux))
    else $error("mux write lost");
  a_stby_entry: assert property ($rose(standby_out) |->
    $past(sense_mux_select_out) == 3'h7 && !$past(ch5) && !$past(limp_mode_out))
    else $error("bad stand-by entry");
  a_stby_wake: assert property (standby_out && sense_mux_select_out != 3'h7
    |=> !standby_out) else $error("no wake");
  a_limp_sync: assert property ($rose(limp_home_in) && !limp_mode_out
    |=> !limp_mode_out ##[1:4] limp_mode_out) else $error("limp timing");
  a_sense_off: assert property (limp_mode_out && $past(limp_mode_out)
    |-> !current_sense_en_out) else $error("sense on in limp");
  a_limp_pin5: assert property ((limp_mode_out && !pin5) [*6] |-> !ch5)
    else $error("ch5 held in limp");
  a_idle_set: assert property ((sense_mux_select_out != 3'h7 && !limp_mode_out
    && channel_outputs_out == 6'h00) [*3] |-> idle_out) else $error("no idle");
  a_soft_rst: assert property (reg_wr_in && reg_addr_in == 4'h2 &&
    reg_wdata_in[1] && !limp_mode_out && !limp_home_in |-> ##[1:3] reg_reset_out)
    else $error("no soft reset");
  a_ter_reset: assert property (reg_reset_out |->
    transfer_error_out && so_out_reg_sel_out) else $error("flags not reset");
  // Main scenarios
  c_stby: cover property ($rose(standby_out));
  c_limp: cover property ($rose(limp_mode_out));
  c_frame: cover property ($fell(so_out_reg_sel_out));
endmodule

bind smr_core smr_core_checker chk (.clk_in, .nrst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .limp_home_in, .channel_input_pins_in,
  .channel_outputs_out, .sense_mux_select_out, .so_out_reg_sel_out,
  .transfer_error_out, .standby_out, .idle_out, .limp_mode_out,
  .current_sense_en_out, .reg_reset_out);

// *** verification/smr_host_model.sv ***
// Host model: serial frames on select and clock pins
// Assumes a start edge from the bench; clock idles low between frames
`timescale 1ns/1ns
module smr_host_model (
  // Frame request
  input  wire logic       start_in,
  input  wire logic [4:0] nbits_in,
  // Serial pins and completion
  output logic            spi_cs_n_out,
  output logic            spi_sclk_out,
  output logic            done_out
);
  // Idle levels
  initial
  begin
    spi_cs_n_out = 1'b1;
    spi_sclk_out = 1'b0;
    done_out = 1'b1;
  end
  // One frame, 48 ns clock, offset from the bench clock
  always @(posedge start_in)
  begin
    done_out = 1'b0;
    #1 spi_cs_n_out = 1'b0;
    #24;
    repeat (nbits_in)
    begin
      spi_sclk_out = 1'b1;
      #24 spi_sclk_out = 1'b0;
      #24;
    end
    spi_cs_n_out = 1'b1;
    #24 done_out = 1'b1;
  end
endmodule

// *** verification/smr_core_bench.sv ***
// Bench: random and directed runs of stand-by, crank latch and limp-home
// Assumes smr_core with its checker bound and smr_host_model for frames
`timescale 1ns/1ns
`include "smr_defines.svh"
module smr_core_bench;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic       wr = 1'b0;
  logic       rd_s = 1'b0;
  logic       limp_pin = 1'b0;
  logic [5:0] pins = 6'h00;
  logic [5:0] therm = 6'h00;
  logic       go = 1'b0;
  logic [4:0] nbits = 5'h08;
  logic [5:0] p;
  logic [2:0] m;
  wire logic [7:0] rdata;
  wire logic [5:0] outs;
  wire logic [2:0] mux;
  wire logic       cs_n, sclk, fdone, sel, xfer_err, stby, idle, limp, csen, rrst;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  always #2 clk_in = ~clk_in;

  smr_core DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(adr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .limp_home_in(limp_pin),
    .channel_input_pins_in(pins), .thermal_fault_in(therm),
    .channel_outputs_out(outs), .sense_mux_select_out(mux),
    .so_out_reg_sel_out(sel), .transfer_error_out(xfer_err), .standby_out(stby),
    .idle_out(idle), .limp_mode_out(limp), .current_sense_en_out(csen),
    .reg_reset_out(rrst));
  smr_host_model HOST (.start_in(go), .nbits_in(nbits), .spi_cs_n_out(cs_n),
    .spi_sclk_out(sclk), .done_out(fdone));

  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    tests_run++;
    if (got !== ex)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chb(input string nm, input logic ex, input logic got);
    chk(nm, {7'h00, ex}, {7'h00, got});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, input string nm, input logic [7:0] ex);
    @(posedge clk_in);
    rd_s <= 1'b1;
    adr <= a;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk(nm, ex, rdata);
  endtask
  task automatic frame(input int k);
    @(posedge clk_in);
    nbits <= 5'(k);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (int i = 0; i < 400 && !fdone; i++)
      @(posedge clk_in);
    tick(4);
    chb("frame", 1'b1, fdone);
  endtask
  function automatic logic exp_err(input int k);
    return (k % 8 != 0) || (k == 0);
  endfunction

  // Main sequence
  initial
  begin
    void'($urandom(54));
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    tick(3);
    chb("xfer_err", 1'b1, xfer_err);
    chb("sel", 1'b1, sel);
    rdr(`SMR_OFS_OUT, "out", 8'h00);
    rdr(`SMR_OFS_DIAG, "mux", 8'h07);
    rdr(`SMR_OFS_HWCFG, "hw", 8'h06);
    rdr(`SMR_OFS_STAT, "st", 8'h02);
    rdr(4'hF, "unmapped", 8'h00);
    frame(8);
    chb("sel", 1'b0, sel);
    chb("xfer_err", 1'b0, xfer_err);
    for (int j = 0; j < 5; j++)
    begin
      n = 1 + int'($urandom % 16);
      frame(n);
      chb("xfer_err", exp_err(n), xfer_err);
    end
    // Corner: select pulse with no clock at all
    frame(0);
    chb("xfer_err", 1'b1, xfer_err);
    // Wake, idle, thermal latch cleared on stand-by entry
    m = 3'($urandom % 7);
    wrr(`SMR_OFS_DIAG, {5'h00, m});
    tick(3);
    chb("stby", 1'b0, stby);
    chb("idle", 1'b1, idle);
    chb("csen", 1'b1, csen);
    rdr(`SMR_OFS_HWCFG, "hw", 8'h04);
    @(posedge clk_in);
    therm <= 6'h01;
    repeat (3) @(posedge clk_in);
    therm <= 6'h00;
    rdr(`SMR_OFS_THERM, "therm", 8'h01);
    wrr(`SMR_OFS_DIAG, 8'h07);
    tick(3);
    chb("stby", 1'b1, stby);
    rdr(`SMR_OFS_THERM, "therm", 8'h00);
    // Random channel drive, awake
    wrr(`SMR_OFS_DIAG, 8'h03);
    p = 6'($urandom % 32);
    m = 3'($urandom % 8);
    wrr(`SMR_OFS_OUT, {5'h00, m});
    @(posedge clk_in);
    pins <= p;
    tick(6);
    chk("outs", {2'b00, p | {3'h0, m}}, {2'b00, outs});
    chb("idle", (p | {3'h0, m}) == 6'h00, idle);
    @(posedge clk_in);
    pins <= 6'h00;
    // Crank latch through soft reset
    wrr(`SMR_OFS_OUT, 8'h20);
    tick(6);
    wrr(`SMR_OFS_OUT, 8'h00);
    wrr(`SMR_OFS_DIAG, 8'h07);
    tick(6);
    chb("ch5", 1'b1, outs[5]);
    chb("stby", 1'b0, stby);
    rdr(`SMR_OFS_HWCFG, "hw", 8'h0C);
    wrr(`SMR_OFS_HWCFG, 8'h06);
    tick(3);
    chb("xfer_err", 1'b1, xfer_err);
    chb("sel", 1'b1, sel);
    chb("ch5", 1'b1, outs[5]);
    wrr(`SMR_OFS_HWCFG, 8'h00);
    tick(6);
    chb("ch5", 1'b0, outs[5]);
    chb("stby", 1'b1, stby);
    // Limp-home
    wrr(`SMR_OFS_DIAG, 8'h03);
    wrr(`SMR_OFS_OUT, 8'h03);
    @(posedge clk_in);
    limp_pin <= 1'b1;
    tick(8);
    chb("limp", 1'b1, limp);
    chb("csen", 1'b0, csen);
    chb("rrst", 1'b1, rrst);
    rdr(`SMR_OFS_DIAG, "mux", 8'h07);
    chk("mux_out", 8'h07, {5'h00, mux});
    rdr(`SMR_OFS_STAT, "st", 8'h03);
    wrr(`SMR_OFS_DIAG, 8'h02);
    rdr(`SMR_OFS_DIAG, "mux", 8'h07);
    p = 6'($urandom) | 6'h20;
    @(posedge clk_in);
    pins <= p;
    tick(6);
    chk("outs", {2'b00, p}, {2'b00, outs});
    @(posedge clk_in);
    pins <= 6'h00;
    tick(6);
    chk("outs", 8'h00, {2'b00, outs});
    @(posedge clk_in);
    limp_pin <= 1'b0;
    tick(8);
    chb("limp", 1'b0, limp);
    chb("rrst", 1'b0, rrst);
    chb("stby", 1'b1, stby);
    end_of_test();
  end
endmodule
